/* rtl/col_drv_pkg.sv */
package col_drv_pkg;

    // ----------------------------------------------------------------
    // geometry
    // ----------------------------------------------------------------
    localparam int COLS = 40;
    localparam int TAP_LO = 20;
    localparam int TAP_MID = 30;
    localparam int TAP_HI = 40;
    localparam int FIFO_W = 1;
    localparam int FIFO_D = 8;
    localparam int FIFO_AW = 3;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [COLS-1:0] SHIFT_RST = 40'h00_0000_0000;
    localparam logic [COLS-1:0] LATCH_RST = 40'h00_0000_0000;
    localparam logic [1:0] SYNC_RST = 2'h3;

    // ----------------------------------------------------------------
    // drive level codes for each column selector
    // ----------------------------------------------------------------
    typedef enum logic [1:0]
    {
        LVL_POS_SUPPLY = 2'b00,
        LVL_TWO = 2'b01,
        LVL_THREE = 2'b10,
        LVL_MOST_NEG = 2'b11
    } drive_level_t;

endpackage

/* rtl/bit_stream_if.sv */
`timescale 1ns/1ns
// one-bit stream with valid/ready between shift front end and fifo
interface bit_stream_if;
    logic valid;
    logic ready;
    logic data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* rtl/bit_fifo.sv */
`timescale 1ns/1ns
module bit_fifo
#(
    parameter int WIDTH = 1,
    parameter int DEPTH = 8,
    parameter int AW = 3
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    typedef struct packed
    {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } fifo_st_t;

    fifo_st_t st_r;
    fifo_st_t st_nxt;
    logic push;
    logic pop;

    // ----------------------------------------------------------------
    // handshake
    // ----------------------------------------------------------------
    assign in_ready = (st_r.cnt != (AW+1)'(DEPTH));
    assign out_valid = (st_r.cnt != '0);
    assign out_data = st_r.mem[st_r.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // pointers wrap naturally since depth is a power of two
    always_comb
    begin
        st_nxt = st_r;
        if (push)
        begin
            st_nxt.mem[st_r.wp] = in_data;
            st_nxt.wp = st_r.wp + AW'(1);
        end
        if (pop)
            st_nxt.rp = st_r.rp + AW'(1);
        st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    // an overfull count would mean a push slipped past in_ready
    property p_fifo_count;
        @(posedge clk) disable iff (!nrst)
        st_r.cnt <= (AW+1)'(DEPTH);
    endproperty
    a_fifo_count: assert property (p_fifo_count) else $error("fifo count over depth");
endmodule

/* rtl/lcd_column_serial_latch_driver.sv */
`timescale 1ns/1ns
// Notes on behaviour
// - falling serial clock captures data into stage one
// - each falling edge shifts forty stages once
// - die variant taps stages twenty and forty
// - packaged variant single carry from stage thirty
// - falling strobe copies all bits into latch
// - latch holds until next falling strobe
// - per column one-of-four selector, phase and bit
// - selector picks among four external levels
// - phase high follows bit, low inverts it
module lcd_column_serial_latch_driver
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic serial_clk,
    input wire logic serial_data,
    input wire logic transfer_strobe,
    input wire logic phase_select,
    output logic carry_stage20,
    output logic carry_stage40,
    output logic carry_stage30,
    output logic [col_drv_pkg::COLS-1:0] column_bit,
    output logic [2*col_drv_pkg::COLS-1:0] column_level
);
    import col_drv_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed
    {
        logic [1:0] sclk_sync;
        logic [1:0] sdat_sync;
        logic [1:0] strb_sync;
        logic [1:0] phase_sync;
        logic sclk_prev;
        logic strb_prev;
        logic [COLS-1:0] shift;
        logic [COLS-1:0] latch;
        logic [2*COLS-1:0] level;
        logic phase;
    } drv_st_t;

    drv_st_t st_r;
    drv_st_t st_nxt;
    logic sclk_fall;
    logic strb_fall;
    logic fifo_out_valid;
    logic fifo_out_data;
    logic fifo_in_ready;
    bit_stream_if capture_if ();

    // edge detectors read only the second synchroniser stage
    assign sclk_fall = st_r.sclk_prev && !st_r.sclk_sync[1];
    assign strb_fall = st_r.strb_prev && !st_r.strb_sync[1];

    // ----------------------------------------------------------------
    // capture fifo: serial bits queue here so a strobe and a clock edge
    // landing together are both honoured in order
    // ----------------------------------------------------------------
    assign capture_if.valid = sclk_fall;
    assign capture_if.data = st_r.sdat_sync[1];
    assign fifo_in_ready = capture_if.ready;

    bit_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D), .AW(FIFO_AW)) u_fifo
    (
        .clk(clk),
        .nrst(nrst),
        .in_valid(capture_if.valid),
        .in_ready(capture_if.ready),
        .in_data(capture_if.data),
        .out_valid(fifo_out_valid),
        .out_ready(!strb_fall),
        .out_data(fifo_out_data)
    );

    // next state: one shift per bit, strobe takes priority for a cycle
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.sclk_sync = {st_r.sclk_sync[0], serial_clk};
        st_nxt.sdat_sync = {st_r.sdat_sync[0], serial_data};
        st_nxt.strb_sync = {st_r.strb_sync[0], transfer_strobe};
        st_nxt.phase_sync = {st_r.phase_sync[0], phase_select};
        st_nxt.sclk_prev = st_r.sclk_sync[1];
        st_nxt.strb_prev = st_r.strb_sync[1];
        st_nxt.phase = st_r.phase_sync[1];
        if (strb_fall)
            st_nxt.latch = st_r.shift;
        else if (fifo_out_valid)
            st_nxt.shift = {st_r.shift[COLS-2:0], fifo_out_data};
        // latch otherwise untouched by shifting
        for (int i = 0; i < COLS; i++)
        begin
            // phase high: bit 1 -> supply, 0 -> level three;
            // phase low: bit 1 -> most negative, 0 -> level two
            if (st_nxt.phase)
                st_nxt.level[2*i +: 2] = st_nxt.latch[i] ? LVL_POS_SUPPLY : LVL_THREE;
            else
                st_nxt.level[2*i +: 2] = st_nxt.latch[i] ? LVL_MOST_NEG : LVL_TWO;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r.sclk_sync <= SYNC_RST;
            st_r.sdat_sync <= 2'h0;
            st_r.strb_sync <= SYNC_RST;
            st_r.phase_sync <= SYNC_RST;
            st_r.sclk_prev <= 1'b1;
            st_r.strb_prev <= 1'b1;
            st_r.shift <= SHIFT_RST;
            st_r.latch <= LATCH_RST;
            // matches latch zero at phase high, so no stale level after reset
            st_r.level <= {COLS{LVL_THREE}};
            st_r.phase <= 1'b1;
        end
        else
            st_r <= st_nxt;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign carry_stage20 = st_r.shift[TAP_LO-1];
    assign carry_stage40 = st_r.shift[TAP_HI-1];
    assign carry_stage30 = st_r.shift[TAP_MID-1];
    // data view of the selector: follows bit when phase high
    always_comb
    begin
        for (int i = 0; i < COLS; i++)
            column_bit[i] = (st_r.level[2*i +: 2] == LVL_POS_SUPPLY) || (st_r.level[2*i +: 2] == LVL_TWO);
    end
    assign column_level = st_r.level;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_strobe_fall;
        strb_fall;
    endsequence

    property p_shift_in;
        @(posedge clk) disable iff (!nrst)
        (fifo_out_valid && !strb_fall) |=> st_r.shift[0] == $past(fifo_out_data) &&
            st_r.shift[COLS-1:1] == $past(st_r.shift[COLS-2:0]);
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("shift step wrong");

    property p_capture;
        @(posedge clk) disable iff (!nrst)
        (sclk_fall && fifo_in_ready) |=> fifo_out_valid;
    endproperty
    a_capture: assert property (p_capture) else $error("captured bit lost");

    property p_latch_load;
        @(posedge clk) disable iff (!nrst)
        s_strobe_fall |=> st_r.latch == $past(st_r.shift);
    endproperty
    a_latch_load: assert property (p_latch_load) else $error("latch not loaded");

    property p_latch_hold;
        @(posedge clk) disable iff (!nrst)
        !strb_fall |=> $stable(st_r.latch);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch changed without strobe");

    // each tap must show the bit that sat one stage below it before the shift
    property p_carry;
        @(posedge clk) disable iff (!nrst)
        (fifo_out_valid && !strb_fall) |=> carry_stage20 == $past(st_r.shift[TAP_LO-2]) &&
            carry_stage30 == $past(st_r.shift[TAP_MID-2]) && carry_stage40 == $past(st_r.shift[TAP_HI-2]);
    endproperty
    a_carry: assert property (p_carry) else $error("carry tap wrong");

    property p_level_hi;
        @(posedge clk) disable iff (!nrst)
        st_r.phase |-> column_level[1:0] == (st_r.latch[0] ? LVL_POS_SUPPLY : LVL_THREE);
    endproperty
    a_level_hi: assert property (p_level_hi) else $error("phase high level wrong");

    property p_level_lo;
        @(posedge clk) disable iff (!nrst)
        !st_r.phase |-> column_level[1:0] == (st_r.latch[0] ? LVL_MOST_NEG : LVL_TWO);
    endproperty
    a_level_lo: assert property (p_level_lo) else $error("phase low level wrong");

    property p_polarity;
        @(posedge clk) disable iff (!nrst)
        column_bit[5] == (st_r.phase ? st_r.latch[5] : !st_r.latch[5]);
    endproperty
    a_polarity: assert property (p_polarity) else $error("column polarity wrong");
endmodule

/* test/serial_ctrl_model.sv */
`timescale 1ns/1ns
// controller side of the link: serial clock, data, transfer strobe, phase
module serial_ctrl_model
(
    input wire logic clk,
    output logic serial_clk,
    output logic serial_data,
    output logic transfer_strobe,
    output logic phase_select
);
    import col_drv_pkg::*;
    localparam int HALF = 50; // 500 ns high and low at 10 ns
    localparam int LATCH_SETUP = 63; // 630 ns of setup before the strobe falls
    localparam int LATCH_WIDTH = 25; // 250 ns strobe low

    // pins idle high; serial clock stands still outside frames
    initial
    begin
        serial_clk = 1'b1;
        serial_data = 1'b1;
        transfer_strobe = 1'b1;
        phase_select = 1'b1;
    end

    // last n bits of w, msb first; after its hold the data line shows the inverse
    task automatic send_bits(input logic [COLS-1:0] w, input int n);
        for (int i = n - 1; i >= 0; i--)
        begin
            @(posedge clk);
            serial_data <= w[i];
            repeat (HALF) @(posedge clk);
            serial_clk <= 1'b0;
            repeat (HALF) @(posedge clk);
            serial_clk <= 1'b1;
            serial_data <= ~w[i];
        end
    endtask

    // strobe well after the last fall so the final bit is already shifted
    task automatic pulse_strobe();
        repeat (LATCH_SETUP) @(posedge clk);
        transfer_strobe <= 1'b0;
        repeat (LATCH_WIDTH) @(posedge clk);
        transfer_strobe <= 1'b1;
        repeat (10) @(posedge clk);
    endtask

    // phase marks the half of the multiplex cycle
    task automatic set_phase(input logic p);
        @(posedge clk);
        phase_select <= p;
        repeat (8) @(posedge clk);
    endtask
endmodule

/* test/testbench.sv */
`timescale 1ns/1ns
module testbench;
    import col_drv_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic serial_clk;
    logic serial_data;
    logic transfer_strobe;
    logic phase_select;
    logic carry_stage20;
    logic carry_stage40;
    logic carry_stage30;
    logic [COLS-1:0] column_bit;
    logic [2*COLS-1:0] column_level;
    logic [COLS-1:0] next_column_bit;
    int fails = 0;
    int samples_checked = 0;
    localparam logic [COLS-1:0] W1 = 40'hc5_a3_96_0f_e1;
    localparam logic [COLS-1:0] W2 = 40'h12_34_56_78_9a;
    localparam logic [COLS-1:0] W3 = {W2[COLS-6:0], 5'h16};

    // 100 mhz clock
    always #5 clk = ~clk;

    lcd_column_serial_latch_driver dut
    (
        .clk(clk),
        .nrst(nrst),
        .serial_clk(serial_clk),
        .serial_data(serial_data),
        .transfer_strobe(transfer_strobe),
        .phase_select(phase_select),
        .carry_stage20(carry_stage20),
        .carry_stage40(carry_stage40),
        .carry_stage30(carry_stage30),
        .column_bit(column_bit),
        .column_level(column_level)
    );

    serial_ctrl_model ctrl
    (
        .clk(clk),
        .serial_clk(serial_clk),
        .serial_data(serial_data),
        .transfer_strobe(transfer_strobe),
        .phase_select(phase_select)
    );

    // second driver in the chain, fed from the first one's last stage
    lcd_column_serial_latch_driver dut_next
    (
        .clk(clk),
        .nrst(nrst),
        .serial_clk(serial_clk),
        .serial_data(carry_stage40),
        .transfer_strobe(transfer_strobe),
        .phase_select(phase_select),
        .carry_stage20(),
        .carry_stage40(),
        .carry_stage30(),
        .column_bit(next_column_bit),
        .column_level()
    );

    // ----------------------------------------------------------------
    // comparison helpers
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [2*COLS-1:0] exp, input logic [2*COLS-1:0] got);
        samples_checked++;
        if (exp !== got)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // expected codes built per column from bit and phase
    task automatic check_cols(input logic [COLS-1:0] w, input logic ph);
        logic [2*COLS-1:0] lvl;
        drive_level_t code;
        for (int i = 0; i < COLS; i++)
        begin
            if (ph)
                code = w[i] ? LVL_POS_SUPPLY : LVL_THREE;
            else
                code = w[i] ? LVL_MOST_NEG : LVL_TWO;
            lvl[2*i +: 2] = code;
        end
        check("column_bit", {{COLS{1'b0}}, ph ? w : ~w}, {{COLS{1'b0}}, column_bit});
        check("column_level", lvl, column_level);
    endtask

    task automatic check_carry(input logic [COLS-1:0] s);
        check("die taps", {78'h0, s[TAP_LO-1], s[TAP_HI-1]}, {78'h0, carry_stage20, carry_stage40});
        check("packaged carry", {79'h0, s[TAP_MID-1]}, {79'h0, carry_stage30});
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic test_frame_load();
        ctrl.send_bits(W1, COLS);
        repeat (10) @(posedge clk);
        check_carry(W1);
        check_cols('0, 1'b1);
        ctrl.pulse_strobe();
        check_cols(W1, 1'b1);
    endtask

    task automatic test_latch_hold();
        ctrl.send_bits(W2, COLS);
        repeat (10) @(posedge clk);
        check_cols(W1, 1'b1);
        ctrl.pulse_strobe();
        check_cols(W2, 1'b1);
        check("cascaded column_bit", {{COLS{1'b0}}, W1}, {{COLS{1'b0}}, next_column_bit});
    endtask

    // a short burst of five bits, strobed while phase is low
    task automatic test_phase_partial();
        ctrl.set_phase(1'b0);
        check_cols(W2, 1'b0);
        ctrl.send_bits(W3, 5);
        repeat (10) @(posedge clk);
        check_carry(W3);
        ctrl.pulse_strobe();
        check_cols(W3, 1'b0);
        ctrl.set_phase(1'b1);
        check_cols(W3, 1'b1);
    endtask

    // reset in mid-run must clear shift and latch again
    task automatic test_mid_reset();
        @(posedge clk);
        nrst <= 1'b0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        check_cols('0, 1'b1);
        check_carry('0);
    endtask

    task automatic finish_test();
        if (fails == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        check_carry('0);
        test_frame_load();
        test_latch_hold();
        test_phase_partial();
        test_mid_reset();
        finish_test();
    end

    // about 9000 cycles of traffic expected; allow roughly four times that
    initial
    begin
        #400000;
        fails++;
        finish_test();
    end
endmodule
